// *** inc/scb_pkg.sv ***
package scb_pkg;
    localparam int DEPTH_DEF       = 64;
    localparam int DATA_W_DEF      = 8;
    localparam int SEG_MAX         = 8;
    localparam int ADDR_W          = 12;
    localparam int PRE_PCT         = 10;
    localparam int POST_PCT        = 12;
    localparam int PCT_DIV         = 100;
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_STAT   = 12'h004;
    localparam logic [11:0] OFF_RADDR  = 12'h008;
    localparam logic [11:0] OFF_RDATA  = 12'h00C;
    localparam logic [11:0] OFF_TRIG   = 12'h010;
    localparam logic [11:0] OFF_TMASK  = 12'h014;
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_STOP     = 1;
    localparam int CTRL_QUAL     = 2;
    localparam int CTRL_POST     = 3;
    localparam int CTRL_STATEFL  = 4;
    localparam int CTRL_SEG_LSB  = 8;
    localparam int CTRL_SEG_W    = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0100;
    localparam int RDATA_VALID   = 31;

    typedef enum logic [1:0] {
        SCB_IDLE,
        SCB_PREFILL,
        SCB_ARMED,
        SCB_POST
    } scb_state_t;

    typedef struct packed {
        logic run;
        logic stop;
        logic qual_mode;
        logic post_pos;
        logic state_flow;
        logic [3:0] seg_cnt;
    } scb_cfg_t;

    typedef struct packed {
        logic seg_adv;
        logic final_trig;
    } scb_cmd_t;
endpackage

// *** core/scb_apb_slave.sv ***
`timescale 1ns/1ps
module scb_apb_slave
    import scb_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             wr_stb,
    output logic [11:0]      wr_addr,
    output logic [31:0]      wr_data,
    input  wire logic [31:0] rd_ctrl,
    input  wire logic [31:0] rd_stat,
    input  wire logic [31:0] rd_raddr,
    input  wire logic [31:0] rd_rdata,
    input  wire logic [31:0] rd_trig,
    input  wire logic [31:0] rd_tmask
);
    logic hit;
    logic [31:0] rmux;

    // one-cycle access: pready high throughout the access phase
    assign pready  = 1'b1;
    assign wr_stb  = psel & penable & pwrite & hit;
    assign wr_addr = paddr;
    assign wr_data = pwdata;

    always_comb begin
        hit  = 1'b1;
        rmux = 32'h0000_0000;
        unique case (paddr)
            OFF_CTRL:  rmux = rd_ctrl;
            OFF_STAT:  rmux = rd_stat;
            OFF_RADDR: rmux = rd_raddr;
            OFF_RDATA: rmux = rd_rdata;
            OFF_TRIG:  rmux = rd_trig;
            OFF_TMASK: rmux = rd_tmask;
            default:   hit  = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~hit;
    assign prdata  = rmux;
endmodule

// *** core/scb_capture.sv ***
`timescale 1ns/1ps
// How it works
// - segments capture continuously, back-to-back in memory
// - next segment trigger evaluated on next sample
// - post-fill done or next trigger advances segment
// - preempted locations stay marked empty
// - pre position: tenth before trigger
// - trigger at activation skips pre slots; empty unless continuous prefill filled them
// - one position setting for every segment
// - state flow: advance and final commands trigger
// - non-segmented continuous mode fills memory before triggering
// - continuous: data and triggering after full
// - stop before first trigger gives no dump
// - qualified mode triggers from first sample
// - early trigger jumps to post fill
// - post position keeps twelve percent after
// - don't-care qualifier stores every sample
module scb_capture
    import scb_pkg::*;
#(
    parameter int DEPTH  = DEPTH_DEF,
    parameter int DATA_W = DATA_W_DEF
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RST,
    input  wire logic [DATA_W-1:0] TAP_DATA,
    input  wire logic              QUAL_EN,
    input  wire scb_pkg::scb_cmd_t FLOW_CMD,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    output logic                   DONE,
    output logic                   DUMP_READY
);
    import scb_pkg::*;
    localparam int AW = $clog2(DEPTH);

    logic [DATA_W-1:0] mem [DEPTH];
    logic [DEPTH-1:0]  vld_r, vld_nxt;
    scb_state_t        st_r, st_nxt;
    scb_cfg_t          cfg_r, cfg_nxt;
    logic [AW-1:0]     wptr_r, wptr_nxt;
    logic [AW:0]       fill_r, fill_nxt;
    logic [AW:0]       post_r, post_nxt;
    logic [3:0]        seg_r, seg_nxt;
    logic              trig_seen_r, trig_seen_nxt;
    logic              dump_r, dump_nxt;
    logic [AW-1:0]     raddr_r, raddr_nxt;
    logic [DATA_W-1:0] tval_r, tval_nxt, tmsk_r, tmsk_nxt;
    logic [31:0]       rdata_r;
    logic              wr_stb;
    logic [11:0]       wr_addr;
    logic [31:0]       wr_data;
    logic [AW:0]       seg_len, seg_base, pre_len, post_len;
    logic              cond_hit, trig, last_seg, store;

    scb_apb_slave u_apb (
        .CORE_CLK (CORE_CLK),
        .RST      (RST),
        .psel     (PSEL),
        .penable  (PENABLE),
        .pwrite   (PWRITE),
        .paddr    (PADDR),
        .pwdata   (PWDATA),
        .prdata   (PRDATA),
        .pready   (PREADY),
        .pslverr  (PSLVERR),
        .wr_stb   (wr_stb),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .rd_ctrl  ({20'h0, cfg_r.seg_cnt, 3'h0, cfg_r.state_flow,
                    cfg_r.post_pos, cfg_r.qual_mode, 2'h0}),
        .rd_stat  ({26'h0, dump_r, trig_seen_r, seg_r[1:0], st_r}),
        .rd_raddr (32'(raddr_r)),
        .rd_rdata (rdata_r),
        .rd_trig  (32'(tval_r)),
        .rd_tmask (32'(tmsk_r))
    );

    // equal segments from depth and count
    always_comb begin
        seg_len  = (AW+1)'(DEPTH / ((cfg_r.seg_cnt == 4'h0) ? 1
                   : int'(cfg_r.seg_cnt)));
        seg_base = (AW+1)'(int'(seg_len) * int'(seg_r));
        // same position applied to each segment
        pre_len  = (AW+1)'(int'(seg_len) * PRE_PCT / PCT_DIV);
        // twelve percent kept after trigger with post position set, else all but the pre part
        // rounded up, so a 64-sample segment keeps eight
        post_len = cfg_r.post_pos
                   ? (AW+1)'((int'(seg_len) * POST_PCT + PCT_DIV - 1)
                             / PCT_DIV)
                   : (AW+1)'(int'(seg_len) - int'(pre_len));
        if (post_len == '0) post_len = (AW+1)'(1);
    end

    assign cond_hit = ((TAP_DATA ^ tval_r) & tmsk_r) == '0;
    // state flow triggers on advance and final commands
    assign trig = cfg_r.state_flow
                  ? (last_seg ? FLOW_CMD.final_trig : FLOW_CMD.seg_adv)
                  : cond_hit;
    assign last_seg = (seg_r + 4'h1 >= cfg_r.seg_cnt) ||
                      (cfg_r.seg_cnt == 4'h0);
    // qualifier don't-care (QUAL_EN high) stores all
    assign store = !cfg_r.qual_mode || QUAL_EN;

    always_comb begin
        st_nxt        = st_r;
        cfg_nxt       = cfg_r;
        vld_nxt       = vld_r;
        wptr_nxt      = wptr_r;
        fill_nxt      = fill_r;
        post_nxt      = post_r;
        seg_nxt       = seg_r;
        trig_seen_nxt = trig_seen_r;
        dump_nxt      = dump_r;
        raddr_nxt     = raddr_r;
        tval_nxt      = tval_r;
        tmsk_nxt      = tmsk_r;
        cfg_nxt.run   = 1'b0;
        cfg_nxt.stop  = 1'b0;
        if (wr_stb) begin
            unique case (wr_addr)
                OFF_CTRL: begin
                    cfg_nxt.run        = wr_data[CTRL_RUN];
                    cfg_nxt.stop       = wr_data[CTRL_STOP];
                    cfg_nxt.qual_mode  = wr_data[CTRL_QUAL];
                    cfg_nxt.post_pos   = wr_data[CTRL_POST];
                    cfg_nxt.state_flow = wr_data[CTRL_STATEFL];
                    cfg_nxt.seg_cnt    =
                        wr_data[CTRL_SEG_LSB +: CTRL_SEG_W];
                end
                OFF_RADDR: raddr_nxt = wr_data[AW-1:0];
                OFF_TRIG:  tval_nxt  = wr_data[DATA_W-1:0];
                OFF_TMASK: tmsk_nxt  = wr_data[DATA_W-1:0];
                default: ;
            endcase
        end
        unique case (st_r)
            SCB_IDLE: begin
                if (cfg_r.run) begin
                    vld_nxt       = '0;
                    wptr_nxt      = '0;
                    fill_nxt      = '0;
                    seg_nxt       = '0;
                    trig_seen_nxt = 1'b0;
                    dump_nxt      = 1'b0;
                    // only a non-segmented continuous run prefills
                    st_nxt        = (cfg_r.qual_mode || cfg_r.seg_cnt > 4'h1)
                                    ? SCB_ARMED : SCB_PREFILL;
                end
            end
            SCB_PREFILL: begin
                // continuous: fill whole memory, no trigger
                vld_nxt[wptr_r] = 1'b1;
                wptr_nxt = wptr_r + AW'(1);
                if (wptr_r == AW'(DEPTH-1)) begin
                    wptr_nxt = '0;
                    // data ready, triggering starts when full
                    dump_nxt = 1'b1;
                    st_nxt   = SCB_ARMED;
                end
            end
            SCB_ARMED: begin
                // trigger checked while samples are written
                // early trigger goes straight to post fill
                // trigger at activation: pre slots skipped, holding only prefill samples in continuous mode
                if (trig) begin
                    trig_seen_nxt = 1'b1;
                    post_nxt      = post_len;
                    st_nxt        = SCB_POST;
                    if (fill_r < pre_len && !cfg_r.qual_mode &&
                        seg_r == '0 && dump_r) begin
                        fill_nxt = fill_r;
                    end
                    if (fill_r < pre_len) begin
                        wptr_nxt = AW'(seg_base + pre_len);
                        fill_nxt = pre_len;
                    end
                end else if (store) begin
                    vld_nxt[wptr_r] = 1'b1;
                    fill_nxt = (fill_r < pre_len) ? fill_r + 1'b1
                                                  : fill_r;
                    wptr_nxt = (wptr_r + AW'(1) >= AW'(seg_base + pre_len))
                               ? AW'(seg_base) : wptr_r + AW'(1);
                end
            end
            SCB_POST: begin
                if (store && post_r != '0) begin
                    vld_nxt[wptr_r] = 1'b1;
                    wptr_nxt = wptr_r + AW'(1);
                    post_nxt = post_r - 1'b1;
                end
                // next segment's trigger watched right away
                // post-fill end or next trigger advances
                if (post_r == (AW+1)'(1) || (!last_seg && trig)) begin
                    if (last_seg) begin
                        dump_nxt = 1'b1;
                        st_nxt   = SCB_IDLE;
                    end else begin
                        seg_nxt  = seg_r + 4'h1;
                        wptr_nxt = AW'(seg_base + seg_len);
                        fill_nxt = '0;
                        st_nxt   = SCB_ARMED;
                    end
                end
            end
        endcase
        // stop before any trigger gives no dump
        if (cfg_r.stop && st_r != SCB_IDLE) begin
            st_nxt   = SCB_IDLE;
            dump_nxt = trig_seen_r;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_r        <= SCB_IDLE;
            cfg_r       <= '{run:        1'b0,
                             stop:       1'b0,
                             qual_mode:  CTRL_RST[CTRL_QUAL],
                             post_pos:   CTRL_RST[CTRL_POST],
                             state_flow: CTRL_RST[CTRL_STATEFL],
                             seg_cnt:    CTRL_RST[CTRL_SEG_LSB +: CTRL_SEG_W]};
            vld_r       <= '0;
            wptr_r      <= '0;
            fill_r      <= '0;
            post_r      <= '0;
            seg_r       <= '0;
            trig_seen_r <= 1'b0;
            dump_r      <= 1'b0;
            raddr_r     <= '0;
            tval_r      <= '0;
            tmsk_r      <= '0;
        end else begin
            st_r        <= st_nxt;
            cfg_r       <= cfg_nxt;
            vld_r       <= vld_nxt;
            wptr_r      <= wptr_nxt;
            fill_r      <= fill_nxt;
            post_r      <= post_nxt;
            seg_r       <= seg_nxt;
            trig_seen_r <= trig_seen_nxt;
            dump_r      <= dump_nxt;
            raddr_r     <= raddr_nxt;
            tval_r      <= tval_nxt;
            tmsk_r      <= tmsk_nxt;
        end
    end

    // memory has no reset; the valid bits mark empties
    always_ff @(posedge CORE_CLK) begin
        if (st_r != SCB_IDLE && vld_nxt[wptr_r] && store)
            mem[wptr_r] <= TAP_DATA;
    end

    // empty locations read back with valid clear
    always_ff @(posedge CORE_CLK) begin
        if (RST)
            rdata_r <= 32'h0000_0000;
        else if (dump_r && vld_r[raddr_r])
            rdata_r <= {1'b1, 31'(mem[raddr_r])};
        else
            rdata_r <= 32'h0000_0000;
    end

    assign DONE       = dump_r && st_r == SCB_IDLE;
    assign DUMP_READY = dump_r;

    // no dump when stopped before trigger
    a_stop_no_dump: assert property (@(posedge CORE_CLK) disable iff (RST)
        cfg_r.stop && st_r != SCB_IDLE && !trig_seen_r |=> !dump_r)
        else $error("dump after early stop");
    // continuous data not ready before full
    a_prefill_hidden: assert property (@(posedge CORE_CLK) disable iff (RST)
        st_r == SCB_PREFILL |-> !dump_r)
        else $error("data ready during prefill");
    a_prefill_notrig: assert property (@(posedge CORE_CLK) disable iff (RST)
        st_r == SCB_PREFILL |=> st_r != SCB_POST)
        else $error("trigger during prefill");
    a_qual_arms: assert property (@(posedge CORE_CLK) disable iff (RST)
        st_r == SCB_IDLE && cfg_r.run && cfg_r.qual_mode
        |=> st_r == SCB_ARMED)
        else $error("qualified mode not armed");
    // trigger goes to post fill next cycle
    a_trig_post: assert property (@(posedge CORE_CLK) disable iff (RST)
        st_r == SCB_ARMED && trig && !cfg_r.stop |=> st_r == SCB_POST)
        else $error("trigger not taken");
    a_ptr_step: assert property (@(posedge CORE_CLK) disable iff (RST)
        st_r == SCB_POST && store && post_r > 2 && !trig && !cfg_r.stop
        |=> wptr_r == $past(wptr_r) + 1'b1)
        else $error("pointer did not advance");
    a_preempt: assert property (@(posedge CORE_CLK) disable iff (RST)
        st_r == SCB_POST && !last_seg && trig && !cfg_r.stop
        |=> seg_r == $past(seg_r) + 4'h1)
        else $error("segment not advanced");
    a_run_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        st_r == SCB_IDLE && cfg_r.run |=> vld_r == '0)
        else $error("valid bits not cleared");
endmodule

// *** tb/scb_host_model.sv ***
`timescale 1ns/1ps
module scb_host_model (
    input  wire logic        CORE_CLK,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic hung;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        hung = 1'b0;
    end

    // call just after a rising edge; one idle edge follows the release
    task automatic xfer(input logic wr, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q,
            output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge CORE_CLK);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (pready !== 1'b1 && n < 40);
        hung = (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge CORE_CLK);
    endtask
endmodule

// *** tb/segmented_capture_buffer_control_test.sv ***
`timescale 1ns/1ps
module segmented_capture_buffer_control_test;
    import scb_pkg::*;
    localparam int DEPTH = 64;
    logic        CORE_CLK, RST, QUAL_EN, psel, penable, pwrite, er;
    logic        pready, pslverr, DONE, DUMP_READY;
    logic [7:0]  tap;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    scb_cmd_t    cmd;
    int          mismatches, cmp_count, c, n;

    scb_capture #(.DEPTH(DEPTH), .DATA_W(8)) scb_capture_i (
        .CORE_CLK(CORE_CLK), .RST(RST), .TAP_DATA(tap),
        .QUAL_EN(QUAL_EN), .FLOW_CMD(cmd), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DONE(DONE), .DUMP_READY(DUMP_READY));

    scb_host_model scb_host_model_i (
        .CORE_CLK(CORE_CLK), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    // counting tap data makes every stored sample distinct
    always @(posedge CORE_CLK) tap <= tap + 8'h01;

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic xf(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        scb_host_model_i.xfer(w, a, d, rq, er);
        if (scb_host_model_i.hung === 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: bus hung", $time);
            close_out();
        end
    endtask

    task automatic rst_go();
        RST <= 1'b1;
        repeat (6) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(posedge CORE_CLK);
    endtask

    task automatic run_cfg(input logic [31:0] v, input logic [31:0] m);
        xf(1'b1, OFF_TRIG, 32'h0000_0100);
        xf(1'b1, OFF_TMASK, m);
        xf(1'b1, OFF_CTRL, v);
        xf(1'b1, OFF_CTRL, v | 32'h0000_0001);
    endtask

    task automatic wait_done(input int lim);
        c = 0;
        while (DONE !== 1'b1 && c < lim) begin
            @(posedge CORE_CLK);
            c++;
        end
        if (DONE !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: no completion", $time);
            close_out();
        end
    endtask

    // empty locations read back with the valid bit low
    task automatic count_valid(input int lo, input int hi);
        n = 0;
        for (int i = lo; i < hi; i++) begin
            xf(1'b1, OFF_RADDR, 32'(i));
            repeat (2) @(posedge CORE_CLK);
            xf(1'b0, OFF_RDATA, 32'h0000_0000);
            if (rq[RDATA_VALID] === 1'b1)
                n++;
        end
    endtask

    task automatic t_regs();
        xf(1'b0, OFF_CTRL, 32'h0000_0000);
        chk(rq, CTRL_RST);
        xf(1'b0, OFF_STAT, 32'h0000_0000);
        chk(rq, 32'h0000_0000);
        xf(1'b0, 12'h020, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        $display("test regs done");
    endtask

    task automatic t_cont();
        rst_go();
        run_cfg(32'h0000_0108, 32'h0000_0000);
        wait_done(300);
        chk(c >= DEPTH, 1);
        chk(c <= DEPTH + 30, 1);
        count_valid(0, DEPTH);
        chk(n, DEPTH);
        chk(DUMP_READY, 1);
        $display("test continuous done");
    endtask

    task automatic t_qual();
        rst_go();
        run_cfg(32'h0000_010C, 32'h0000_0000);
        wait_done(60);
        chk(c <= 30, 1);
        count_valid(0, DEPTH);
        chk(n, 8);
        $display("test qualified done");
    endtask

    task automatic t_seg();
        rst_go();
        run_cfg(32'h0000_0400, 32'h0000_0000);
        wait_done(300);
        for (int s = 0; s < 3; s++) begin
            count_valid(s * 16, s * 16 + 16);
            chk(n, 1);
        end
        count_valid(48, 64);
        chk(n, 16 - 16 * PRE_PCT / PCT_DIV);
        $display("test segments done");
    endtask

    task automatic t_stop();
        rst_go();
        run_cfg(32'h0000_0100, 32'h0000_0100);
        repeat (20) @(posedge CORE_CLK);
        xf(1'b1, OFF_CTRL, 32'h0000_0102);
        repeat (10) @(posedge CORE_CLK);
        chk(DUMP_READY, 0);
        xf(1'b0, OFF_STAT, 32'h0000_0000);
        chk(rq[5], 0);
        $display("test stop done");
    endtask

    task automatic t_flow();
        rst_go();
        run_cfg(32'h0000_0210, 32'h0000_0100);
        repeat (10) @(posedge CORE_CLK);
        cmd <= scb_cmd_t'(2'h2);
        @(posedge CORE_CLK);
        cmd <= scb_cmd_t'(2'h0);
        repeat (40) @(posedge CORE_CLK);
        chk(DONE, 0);
        cmd <= scb_cmd_t'(2'h1);
        @(posedge CORE_CLK);
        cmd <= scb_cmd_t'(2'h0);
        wait_done(100);
        chk(DUMP_READY, 1);
        $display("test flow done");
    endtask

    initial begin
        RST = 1'b1;
        QUAL_EN = 1'b1;
        tap = 8'h00;
        cmd = scb_cmd_t'(2'h0);
        mismatches = 0;
        cmp_count = 0;
        rst_go();
        t_regs();
        t_cont();
        t_qual();
        t_seg();
        t_stop();
        t_flow();
        close_out();
    end
endmodule
